// ---- verif/mts_mem_model.sv ----
// byte memory model answering row load reads, with adjustable wait gap
`timescale 1ns/100ps
`default_nettype none

module mts_mem_model (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [3:0]  gap_i,
    input  wire logic        req_i,
    input  wire logic [63:0] addr_i,
    output logic             ack_o,
    output logic [7:0]       data_o
);
    logic [3:0] wait_q;
    logic [7:0] byte_w;

    // content depends on several address bits
    assign byte_w = addr_i[7:0] ^ addr_i[15:8] ^ 8'hA5;
    assign ack_o  = req_i && (wait_q == 4'h0);
    // off-answer cycles show the inverse, never a stale byte
    assign data_o = ack_o ? byte_w : ~byte_w;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !req_i || ack_o)
            wait_q <= gap_i;
        else
            wait_q <= wait_q - 4'h1;
    end
endmodule

`default_nettype wire

// ---- verif/mts_slice_access_tb.sv ----
// self-checking bench for the matrix tile slice access block
`timescale 1ns/100ps
`default_nettype none
`include "mts_consts.svh"

module mts_slice_access_tb
    import mts_pkg::*;
();
    logic              clk_i = 1'b0;
    logic              sys_rst_i = 1'b1;
    logic              op_valid_i = 1'b0;
    mts_req_type       op_i;
    logic              op_ready_o;
    logic [3:0][31:0]  idx_regs_i;
    logic [7:0][15:0]  preds_i;
    logic [127:0]      src_vec_i;
    logic [127:0]      dest_old_i;
    logic [63:0]       base_reg_i;
    logic [63:0]       sp_i;
    logic              align_chk_i, matrix_en_i, storage_en_i;
    logic              dit_flag_i, abort_i;
    logic [7:0]        tx_depth_i;
    logic              mem_req_o, mem_ack_i, done_o, vec_wr_o;
    logic [63:0]       mem_addr_o;
    logic [7:0]        mem_data_i;
    mts_err_type       err_o;
    logic [127:0]      vec_data_o;
    logic              tag_checked_o, dit_active_o;
    logic [3:0]        gap;
    int                err_total, n_checks, abort_at;
    logic [7:0]        za [16][16];
    mts_err_type       g_err;
    logic [127:0]      g_vec;
    logic              g_wr;

    mts_slice_access DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .op_valid_i(op_valid_i), .op_i(op_i), .op_ready_o(op_ready_o),
        .idx_regs_i(idx_regs_i), .preds_i(preds_i),
        .src_vec_i(src_vec_i), .dest_old_i(dest_old_i),
        .base_reg_i(base_reg_i), .sp_i(sp_i), .align_chk_i(align_chk_i),
        .matrix_en_i(matrix_en_i), .storage_en_i(storage_en_i),
        .dit_flag_i(dit_flag_i), .tx_depth_i(tx_depth_i),
        .abort_i(abort_i), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
        .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i), .done_o(done_o),
        .err_o(err_o), .vec_wr_o(vec_wr_o), .vec_data_o(vec_data_o),
        .tag_checked_o(tag_checked_o), .dit_active_o(dit_active_o));

    mts_mem_model u_mem (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .gap_i(gap), .req_i(mem_req_o), .addr_i(mem_addr_o),
        .ack_o(mem_ack_i), .data_o(mem_data_i));

    always #5 clk_i = ~clk_i;

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk_v(input logic [127:0] g, input logic [127:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %0t vector %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_b(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %0t value %h exp %h", $time, g, e);
        end
    endtask

    function automatic logic [7:0] mb(input logic [63:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction

    // request held until the accepting edge, then wait for done
    task automatic run_op(input mts_req_type rq, output int lat);
        int k;
        @(negedge clk_i);
        op_i = rq;
        op_valid_i = 1'b1;
        for (k = 0; k < 100 && op_ready_o !== 1'b1; k++)
            @(negedge clk_i);
        @(negedge clk_i);
        op_valid_i = 1'b0;
        lat = 1;
        while (done_o !== 1'b1 && lat < 400) begin
            abort_i = (lat == abort_at);
            @(negedge clk_i);
            lat++;
        end
        abort_i = 1'b0;
        g_err = err_o;
        g_vec = vec_data_o;
        g_wr = vec_wr_o;
    endtask

    task automatic mv(input mts_opc_type o, input int sz, vt, tl, sel, im,
                      input int pg);
        mts_req_type rq;
        int lat, n, s, t, r, c, b;
        logic [127:0] e;
        logic act;
        n = 16 >> sz;
        t = tl & ((1 << sz) - 1);
        s = (idx_regs_i[sel][3:0] + (im & (n - 1))) & (n - 1);
        rq = '{o, 3'(sz), 4'(tl), vt[0], 2'(sel), 4'(im), 3'(pg), 5'h00};
        run_op(rq, lat);
        e = dest_old_i;
        for (b = 0; b < 16; b++) begin
            r = vt ? (((b >> sz) << sz) | t) : ((s << sz) | t);
            c = vt ? ((s << sz) | (b & ((1 << sz) - 1))) : b;
            act = preds_i[pg][b & ~((1 << sz) - 1)];
            if (act && o == OP_T2V) e[8*b +: 8] = za[r][c];
            if (act && o == OP_V2T) za[r][c] = src_vec_i[8*b +: 8];
        end
        chk_b(8'(lat), 8'h01);
        chk_b(8'(g_err), 8'h00);
        if (o == OP_T2V) chk_v(g_vec, e);
        chk_b({7'h00, g_wr}, {7'h00, o == OP_T2V});
        chk_b({7'h00, dit_active_o}, {7'h00, dit_flag_i});
    endtask

    task automatic array_row_load(input int sel, im, bn, input logic [3:0] ee,
                       input int el);
        mts_req_type rq;
        int lat, r, c;
        logic [63:0] a;
        r = (idx_regs_i[sel][3:0] + im) & 15;
        a = (bn == 31 ? sp_i : base_reg_i) + 64'(im * 16);
        rq = '{OP_LDR, 3'h0, 4'h0, 1'b0, 2'(sel), 4'(im), 3'h0, 5'(bn)};
        run_op(rq, lat);
        if (ee == 4'h0)
            for (c = 0; c < 16; c++) za[r][c] = mb(a + 64'(c));
        chk_b(8'(g_err), {4'h0, ee});
        chk_b(8'(lat), 8'(el));
        chk_b({7'h00, mem_req_o}, 8'h00);
        if (ee == 4'h0) chk_b({7'h00, tag_checked_o}, {7'h00, bn != 31});
    endtask

    task automatic sweep();
        int sz, vt;
        for (sz = 0; sz < 5; sz++)
            for (vt = 0; vt < 2; vt++) begin
                dit_flag_i = vt[0];
                mv(OP_T2V, sz, vt, 15 - sz, sz % 4, 15, 0);
            end
    endtask

    initial begin
        #200000;
        err_total++;
        report_and_stop();
    end

    initial begin
        int i;
        op_i = '0;
        for (i = 0; i < 4; i++) idx_regs_i[i] = 32'h8765_4322 + 32'(i * 7);
        for (i = 0; i < 8; i++) preds_i[i] = 16'hFFFF ^ 16'(16'h1111 * i);
        src_vec_i = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF;
        dest_old_i = {8{16'hC3A5}};
        base_reg_i = 64'h0000_0000_0001_2300;
        sp_i = 64'h0000_0000_0004_5600;
        {align_chk_i, matrix_en_i, storage_en_i} = 3'h7;
        {dit_flag_i, abort_i, abort_at} = '0;
        tx_depth_i = 8'h00;
        gap = 4'h0;
        repeat (5) @(negedge clk_i);
        sys_rst_i = 1'b0;
        chk_b({5'h00, op_ready_o, mem_req_o, done_o}, 8'h04);
        for (i = 0; i < 16; i++) begin
            gap = 4'(i % 3);
            array_row_load(0, i, i == 15 ? 31 : 3, 4'h0, 16 * (i % 3 + 1) + 1);
        end
        gap = 4'h0;
        array_row_load(3, 5, 2, 4'h0, 17);
        sweep();
        for (i = 1; i < 8; i++)
            mv(OP_T2V, i % 5, i & 1, i, i % 4, i, i);
        mv(OP_V2T, 1, 1, 1, 2, 6, 3);
        mv(OP_V2T, 3, 0, 5, 1, 1, 5);
        mv(OP_T2V, 1, 1, 1, 2, 6, 0);
        mv(OP_T2V, 0, 0, 0, 0, 3, 0);
        matrix_en_i = 1'b0;
        array_row_load(0, 2, 3, 4'h8, 1);
        matrix_en_i = 1'b1;
        storage_en_i = 1'b0;
        array_row_load(1, 2, 3, 4'h8, 1);
        storage_en_i = 1'b1;
        sp_i = 64'h0000_0000_0004_5608;
        tx_depth_i = 8'h03;
        array_row_load(0, 1, 31, 4'h4, 1);
        tx_depth_i = 8'h00;
        align_chk_i = 1'b0;
        array_row_load(0, 1, 31, 4'h2, 1);
        base_reg_i = 64'h0000_0000_0001_2308;
        array_row_load(2, 7, 4, 4'h0, 17);
        align_chk_i = 1'b1;
        array_row_load(0, 1, 4, 4'h2, 1);
        base_reg_i = 64'h0000_0000_0001_2300;
        gap = 4'h3;
        dit_flag_i = 1'b1;
        abort_at = 6;
        array_row_load(1, 4, 7, 4'h1, 7);
        abort_at = 0;
        mv(OP_T2V, 0, 0, 0, 0, 11, 0);
        sweep();
        report_and_stop();
    end
endmodule

`default_nettype wire

// ---- verilog/mts_consts.svh ----
// constants for the matrix tile slice access block
`ifndef MTS_CONSTS_SVH
`define MTS_CONSTS_SVH

// streaming vector length fixed at 128 bits
`define MTS_VL_BITS    128
`define MTS_VL_BYTES   16
`define MTS_VL_SHIFT   4
`define MTS_IDX_MAX    4'hF
`define MTS_SEG_MAX    4'hF
`define MTS_LAST_BYTE  4'hF
`define MTS_ZERO4      4'h0
`define MTS_SP_NUM     5'h1F
`define MTS_ALIGN_MSB  3
`define MTS_NUM_IDX    4
`define MTS_NUM_PRED   8
`define MTS_PRED_BITS  16
`define MTS_IDX_BITS   32
`define MTS_ADDR_BITS  64
`define MTS_TXD_BITS   8

`endif

// ---- verilog/mts_pkg.sv ----
// types and shared helpers for the matrix tile slice access block
`include "mts_consts.svh"

package mts_pkg;

    typedef enum logic [1:0] {
        OP_T2V,
        OP_V2T,
        OP_LDR
    } mts_opc_type;

    typedef enum logic {
        S_IDLE,
        S_LOAD
    } mts_state_type;

    typedef struct packed {
        mts_opc_type opc;
        logic [2:0]  esz;
        logic [3:0]  tile;
        logic        vert;
        logic [1:0]  idx_sel;
        logic [3:0]  imm;
        logic [2:0]  pg_sel;
        logic [4:0]  base_num;
    } mts_req_type;

    typedef struct packed {
        logic undef;
        logic tx_fail;
        logic align_fault;
        logic aborted;
    } mts_err_type;

    // byte lanes inside one element of size 2**sz bytes
    function automatic logic [3:0] mts_emask(input logic [2:0] sz);
        return ~(`MTS_IDX_MAX << sz);
    endfunction

endpackage

// ---- verilog/mts_pred_merge.sv ----
// per-element predicated merge of two vectors
`timescale 1ns/100ps
`default_nettype none
`include "mts_consts.svh"

module mts_pred_merge
    import mts_pkg::*;
(
    input  wire logic [2:0]                esz_i,
    input  wire logic [`MTS_PRED_BITS-1:0] pred_i,
    input  wire logic [`MTS_VL_BITS-1:0]   old_i,
    input  wire logic [`MTS_VL_BITS-1:0]   new_i,
    output logic      [`MTS_VL_BYTES-1:0]  act_o,
    output logic      [`MTS_VL_BITS-1:0]   merged_o
);

    logic [3:0] emask;

    assign emask = mts_emask(esz_i);

    for (genvar b = 0; b < `MTS_VL_BYTES; b++) begin : g_byte
        localparam logic [3:0] BI = 4'(b);
        // lowest predicate bit of element governs
        assign act_o[b] = pred_i[BI & ~emask];
        assign merged_o[b*8 +: 8] = act_o[b] ? new_i[b*8 +: 8]
                                             : old_i[b*8 +: 8];
    end

endmodule
`default_nettype wire

// ---- verilog/mts_slice_access.sv ----
// matrix array storage with tile slice moves and array row load
`timescale 1ns/100ps
`default_nettype none
`include "mts_consts.svh"

module mts_slice_access
    import mts_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic                   op_valid_i,
    input  wire mts_req_type            op_i,
    output logic                        op_ready_o,
    input  wire logic [`MTS_NUM_IDX-1:0][`MTS_IDX_BITS-1:0] idx_regs_i,
    input  wire logic [`MTS_NUM_PRED-1:0][`MTS_PRED_BITS-1:0] preds_i,
    input  wire logic [`MTS_VL_BITS-1:0] src_vec_i,
    input  wire logic [`MTS_VL_BITS-1:0] dest_old_i,
    input  wire logic [`MTS_ADDR_BITS-1:0] base_reg_i,
    input  wire logic [`MTS_ADDR_BITS-1:0] sp_i,
    input  wire logic                   align_chk_i,
    input  wire logic                   matrix_en_i,
    input  wire logic                   storage_en_i,
    input  wire logic                   dit_flag_i,
    input  wire logic [`MTS_TXD_BITS-1:0] tx_depth_i,
    input  wire logic                   abort_i,
    output logic                        mem_req_o,
    output logic [`MTS_ADDR_BITS-1:0]   mem_addr_o,
    input  wire logic                   mem_ack_i,
    input  wire logic [7:0]             mem_data_i,
    output logic                        done_o,
    output mts_err_type                 err_o,
    output logic                        vec_wr_o,
    output logic [`MTS_VL_BITS-1:0]     vec_data_o,
    output logic                        tag_checked_o,
    output logic                        dit_active_o
);

    mts_state_type               state_q;
    mts_state_type               state_d;
    logic [3:0]                  cnt_q;
    logic [3:0]                  cnt_d;
    logic [3:0]                  row_q;
    logic [`MTS_ADDR_BITS-1:0]   addr_q;
    logic [`MTS_ADDR_BITS-1:0]   addr_d;
    logic                        done_q;
    mts_err_type                 err_q;
    mts_err_type                 err_d;
    logic                        vec_wr_q;
    logic [`MTS_VL_BITS-1:0]     vec_q;
    logic                        tag_q;
    logic                        dit_q;
    logic [7:0]                  arr_q [`MTS_VL_BYTES][`MTS_VL_BYTES];
    logic [7:0]                  lbuf_q [`MTS_VL_BYTES];

    logic [`MTS_IDX_BITS-1:0]    idx_w;
    logic [`MTS_PRED_BITS-1:0]   pred_w;
    logic [3:0]                  dmask_w;
    logic [3:0]                  tile_w;
    logic [3:0]                  slice_w;
    logic [3:0]                  lrow_w;
    logic [7:0]                  pos_w [`MTS_VL_BYTES];
    logic [`MTS_VL_BITS-1:0]     slice_rd;
    logic [`MTS_VL_BITS-1:0]     mold_w;
    logic [`MTS_VL_BITS-1:0]     mnew_w;
    logic [`MTS_VL_BITS-1:0]     merged_w;
    logic [`MTS_VL_BYTES-1:0]    act_w;
    logic [`MTS_ADDR_BITS-1:0]   base_w;
    logic [`MTS_ADDR_BITS-1:0]   start_w;
    logic                        use_sp;
    logic                        en_ok;
    logic                        acc_w;
    logic                        bad_en;
    logic                        go_w;
    logic                        t2v_go;
    logic                        v2t_go;
    logic                        ldr_acc;
    logic                        tx_act;
    logic                        sp_bad;
    logic                        mis_w;
    logic                        ldr_txf;
    logic                        ldr_spf;
    logic                        ldr_alf;
    logic                        ldr_go;
    logic                        loading;
    logic                        abrt_w;
    logic                        ack_w;
    logic                        last_w;
    logic                        fin_w;

    // byte b of a slice mapped to {row, byte column} of the array
    function automatic logic [7:0] mts_pos(
        input logic [2:0] sz,
        input logic       vt,
        input logic [3:0] tl,
        input logic [3:0] sl,
        input logic [3:0] b
    );
        logic [3:0] el;
        el = b >> sz;
        if (vt) begin
            mts_pos = {(el << sz) | tl, (sl << sz) | (b & mts_emask(sz))};
        end else begin
            mts_pos = {(sl << sz) | tl, b};
        end
    endfunction

    assign idx_w = idx_regs_i[op_i.idx_sel];
    assign pred_w = preds_i[op_i.pg_sel];

    mts_slice_sel u_sel (
        .esz_i   (op_i.esz),
        .tile_i  (op_i.tile),
        .imm_i   (op_i.imm),
        .idx_i   (idx_w[3:0]),
        .dmask_o (dmask_w),
        .tile_o  (tile_w),
        .slice_o (slice_w),
        .row_o   (lrow_w)
    );

    for (genvar b = 0; b < `MTS_VL_BYTES; b++) begin : g_pos
        localparam logic [3:0] BI = 4'(b);
        assign pos_w[b] = mts_pos(op_i.esz, op_i.vert, tile_w, slice_w, BI);
        assign slice_rd[b*8 +: 8] = arr_q[pos_w[b][7:4]][pos_w[b][3:0]];
    end

    assign mold_w = (op_i.opc == OP_T2V) ? dest_old_i : slice_rd;
    assign mnew_w = (op_i.opc == OP_T2V) ? slice_rd : src_vec_i;

    mts_pred_merge u_merge (
        .esz_i    (op_i.esz),
        .pred_i   (pred_w),
        .old_i    (mold_w),
        .new_i    (mnew_w),
        .act_o    (act_w),
        .merged_o (merged_w)
    );

    assign use_sp = op_i.base_num == `MTS_SP_NUM;
    assign base_w = use_sp ? sp_i : base_reg_i;
    assign start_w = base_w + (`MTS_ADDR_BITS'(op_i.imm) << `MTS_VL_SHIFT);

    assign en_ok   = matrix_en_i & storage_en_i;
    assign acc_w   = (state_q == S_IDLE) & op_valid_i;
    assign bad_en  = acc_w & ~en_ok;
    assign go_w    = acc_w & en_ok;
    assign t2v_go  = go_w & (op_i.opc == OP_T2V);
    assign v2t_go  = go_w & (op_i.opc == OP_V2T);
    assign ldr_acc = go_w & (op_i.opc == OP_LDR);
    assign tx_act  = tx_depth_i != '0;
    assign sp_bad  = use_sp & (sp_i[`MTS_ALIGN_MSB:0] != `MTS_ZERO4);
    // one alignment check for the row
    assign mis_w   = align_chk_i & (start_w[`MTS_ALIGN_MSB:0] != `MTS_ZERO4);
    assign ldr_txf = ldr_acc & tx_act;
    assign ldr_spf = ldr_acc & ~tx_act & sp_bad;
    assign ldr_alf = ldr_acc & ~tx_act & ~sp_bad & mis_w;
    assign ldr_go  = ldr_acc & ~tx_act & ~sp_bad & ~mis_w;

    assign loading = state_q == S_LOAD;
    // abort handled alike whatever the data
    assign abrt_w  = loading & abort_i;
    assign ack_w   = loading & mem_ack_i & ~abort_i;
    assign last_w  = ack_w & (cnt_q == `MTS_LAST_BYTE);
    // moves finish one cycle after acceptance
    assign fin_w   = t2v_go | v2t_go | bad_en | (ldr_acc & ~ldr_go)
                   | last_w | abrt_w;

    assign state_d = ldr_go ? S_LOAD
                   : (last_w | abrt_w) ? S_IDLE : state_q;
    assign cnt_d  = ldr_go ? `MTS_ZERO4 : ack_w ? cnt_q + 4'h1 : cnt_q;
    assign addr_d = ldr_go ? start_w
                  : ack_w ? addr_q + `MTS_ADDR_BITS'(1) : addr_q;

    assign err_d.undef       = bad_en;
    assign err_d.tx_fail     = ldr_txf;
    assign err_d.align_fault = ldr_spf | ldr_alf;
    assign err_d.aborted     = abrt_w;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q  <= S_IDLE;
            cnt_q    <= `MTS_ZERO4;
            row_q    <= `MTS_ZERO4;
            addr_q   <= '0;
            done_q   <= 1'b0;
            err_q    <= '0;
            vec_wr_q <= 1'b0;
            vec_q    <= '0;
            tag_q    <= 1'b0;
            dit_q    <= 1'b0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            addr_q   <= addr_d;
            done_q   <= fin_w;
            err_q    <= err_d;
            vec_wr_q <= t2v_go;
            if (ldr_go) begin
                row_q <= lrow_w;
            end
            if (t2v_go) begin
                vec_q <= merged_w;
            end
            // tag checking only for general base
            if (go_w) begin
                tag_q <= (op_i.opc == OP_LDR) & ~use_sp;
            end
            if (acc_w) begin
                dit_q <= dit_flag_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (ack_w) begin
            lbuf_q[cnt_q] <= mem_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        // inactive slice lanes write back old data
        if (v2t_go) begin
            for (int b = 0; b < `MTS_VL_BYTES; b++) begin
                arr_q[pos_w[b][7:4]][pos_w[b][3:0]] <= merged_w[b*8 +: 8];
            end
        end else if (last_w) begin
            for (int c = 0; c < `MTS_VL_BYTES - 1; c++) begin
                arr_q[row_q][c] <= lbuf_q[c];
            end
            arr_q[row_q][`MTS_VL_BYTES-1] <= mem_data_i;
        end
    end

    assign op_ready_o    = state_q == S_IDLE;
    assign mem_req_o     = loading;
    assign mem_addr_o    = addr_q;
    assign done_o        = done_q;
    assign err_o         = err_q;
    assign vec_wr_o      = vec_wr_q;
    assign vec_data_o    = vec_q;
    assign tag_checked_o = tag_q;
    assign dit_active_o  = dit_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    move_latency_a: assert property (
        dit_flag_i && (t2v_go || v2t_go) |=> done_o && !mem_req_o
    ) else $error("move did not finish in one cycle");

    disabled_trap_a: assert property (
        bad_en |=> done_o && err_o.undef && !vec_wr_o
    ) else $error("disabled access not trapped");

    tx_fail_a: assert property (
        ldr_acc && tx_depth_i != '0 |=> err_o.tx_fail && !mem_req_o
    ) else $error("row load in transaction not failed");

    start_addr_a: assert property (
        ldr_go |=> mem_req_o && mem_addr_o == $past(start_w)
    ) else $error("row load start address wrong");

    byte_step_a: assert property (
        ack_w && !last_w |=> mem_addr_o == $past(mem_addr_o) + 64'h1
    ) else $error("byte address did not step by one");

    sp_align_a: assert property (
        ldr_acc && !tx_act && sp_bad |=> err_o.align_fault && !mem_req_o
    ) else $error("misaligned stack pointer not faulted");

    tag_mode_a: assert property (
        ldr_acc |=> tag_checked_o == ($past(op_i.base_num) != 5'h1F)
    ) else $error("tag checking mode wrong");

    row_align_a: assert property (
        ldr_acc && !tx_act && !sp_bad && mis_w |=> err_o.align_fault
    ) else $error("misaligned row start not faulted");

    keep_lane_a: assert property (
        t2v_go && !act_w[0] |=> vec_data_o[7:0] == $past(dest_old_i[7:0])
    ) else $error("inactive lane of vector changed");

    slice_mod_a: assert property (
        go_w |-> (slice_w & ~dmask_w) == 4'h0
    ) else $error("slice outside element count");

    row_fill_a: assert property (
        last_w |=> arr_q[$past(row_q)][15] == $past(mem_data_i) && done_o
    ) else $error("row not written at load end");

    abort_resp_a: assert property (
        abrt_w |=> err_o.aborted && done_o && op_ready_o
    ) else $error("abort not answered in one cycle");

endmodule
`default_nettype wire

// ---- verilog/mts_slice_sel.sv ----
// slice, tile and array row selection from index and offset
`timescale 1ns/100ps
`default_nettype none
`include "mts_consts.svh"

module mts_slice_sel
    import mts_pkg::*;
(
    input  wire logic [2:0] esz_i,
    input  wire logic [3:0] tile_i,
    input  wire logic [3:0] imm_i,
    input  wire logic [3:0] idx_i,
    output logic      [3:0] dmask_o,
    output logic      [3:0] tile_o,
    output logic      [3:0] slice_o,
    output logic      [3:0] row_o
);

    logic [3:0] seg_mask;
    logic [3:0] imm_m;

    assign dmask_o = `MTS_IDX_MAX >> esz_i;

    assign tile_o = tile_i & mts_emask(esz_i);

    // offset bounded by one 128-bit segment
    assign seg_mask = `MTS_SEG_MAX >> esz_i;
    assign imm_m = imm_i & seg_mask;

    assign slice_o = (idx_i + imm_m) & dmask_o;

    assign row_o = idx_i + imm_i;

endmodule
`default_nettype wire
